// File: verilog/cmab_params.svh
/*
 constants of the configuration memory and its setting decode.
 assumes inclusion by bare name from the package and cmab_top.
*/
`ifndef CMAB_PARAMS_SVH
`define CMAB_PARAMS_SVH

// word addresses of the configuration memory
`define CMAB_ADDR_FIRST 8'h04
`define CMAB_ADDR_LAST 8'h0a
`define CMAB_OFS_ID_ONE 8'h04
`define CMAB_OFS_ID_TWO 8'h05
`define CMAB_OFS_ZERO_POINT 8'h06
`define CMAB_OFS_QUAD_SETUP 8'h07
`define CMAB_OFS_LOCK 8'h08
`define CMAB_OFS_DIAG_DIS 8'h09
`define CMAB_OFS_COMM_SETUP 8'h0a

// word index inside the array (address minus first address)
`define CMAB_IDX_ZP 3'h2
`define CMAB_IDX_QS 3'h3
`define CMAB_IDX_LK 3'h4
`define CMAB_IDX_DD 3'h5
`define CMAB_IDX_CS 3'h6

// quadrature setup fields
`define CMAB_BIT_DIR 9
`define CMAB_BIT_ZMODE 8
`define CMAB_BIT_QEN 7
`define CMAB_HYS_MSB 6
`define CMAB_HYS_LSB 4
`define CMAB_RES_MSB 3
`define CMAB_RES_LSB 0

// diagnosis disable fields
`define CMAB_BIT_FLUX_DIS 1
`define CMAB_BIT_TRACK_DIS 0

// lock field value meaning unlocked
`define CMAB_LOCK_OPEN 2'h3

// reset values of the words
`define CMAB_RST_ID 12'h000
`define CMAB_RST_ZP 12'h000
`define CMAB_RST_QS 12'h0a0
`define CMAB_RST_LK 12'h003
`define CMAB_RST_DD 12'h000
`define CMAB_RST_CS 12'h052

// half turn of the 12-bit angle
`define CMAB_HALF_TURN 12'h800

`endif

// File: verilog/cmab_pkg.sv
/*
 types and decode functions of the configuration memory block.
 assumes cmab_params.svh is on the include path.
*/
`include "cmab_params.svh"

package cmab_pkg;

  typedef logic [11:0] cmab_word_t;
  typedef logic [6:0][11:0] cmab_bank_t;

  // hysteresis code to update threshold in lsb of angle movement
  function automatic logic [2:0] cmab_hys_thresh(input logic [2:0] code);
    logic [2:0] t;
    t = 3'h3;
    case (code)
      3'h0: t = 3'h0;
      3'h1: t = 3'h2;
      3'h3: t = 3'h4;
      3'h4: t = 3'h5;
      default: t = 3'h3;
    endcase
    return t;
  endfunction

  // resolution code to pulses per revolution
  function automatic logic [10:0] cmab_ppr(input logic [3:0] code);
    logic [10:0] p;
    p = 11'h400;
    case (code)
      4'h0: p = 11'h400;
      4'h1: p = 11'h200;
      4'h2: p = 11'h100;
      4'h3: p = 11'h080;
      4'h4: p = 11'h3e8;
      4'h5: p = 11'h384;
      4'h6: p = 11'h320;
      4'h7: p = 11'h2bc;
      4'h8: p = 11'h258;
      4'h9: p = 11'h1f4;
      4'ha: p = 11'h190;
      4'hb: p = 11'h168;
      4'hc: p = 11'h12c;
      4'hd: p = 11'h0c8;
      4'he: p = 11'h064;
      default: p = 11'h032;
    endcase
    return p;
  endfunction

endpackage

// File: verilog/cmab_hyst.sv
/*
 angle hysteresis filter for the quadrature path.
 assumes the angle input is synchronous to core_clk_i.
*/
`timescale 1ns/10ps

module cmab_hyst
  import cmab_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [11:0] angle_i,
  input wire logic [2:0] thresh_i,
  output logic [11:0] filt_o
);

  typedef struct packed {
    logic [11:0] out;
  } cmab_hyst_state_t;

  cmab_hyst_state_t q, d;
  logic [11:0] diff;
  logic [11:0] mag;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    diff = angle_i - q.out;
    mag = diff[11] ? 12'(-diff) : diff;
    if (thresh_i == 3'h0) begin
      d.out = angle_i; // R12
    end else if (mag >= {9'h000, thresh_i}) begin
      // single-lsb dither of the tracking loop never reaches here
      d.out = angle_i; // R13
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign filt_o = q.out;

  ////////////////////////////////////////////////////////////////////////////
  direct_follow_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R12
    thresh_i == 3'h0 |=> filt_o == $past(angle_i))
    else $error("filter did not follow angle");

  dither_mask_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R13
    (thresh_i == 3'h2) && (mag == 12'h001) |=> $stable(filt_o))
    else $error("single lsb step reached output");

endmodule // cmab_hyst

// File: verilog/cmab_top.sv
/*
 configuration memory, access gating, lock, working copies and setting decode.
 assumes a serial front end turning frames into one-cycle access requests,
 and a tracking angle input synchronous to core_clk_i.
*/
`timescale 1ns/10ps
`include "cmab_params.svh"

// Operation
// R01 - words 0x04-0x0a only in user mode
// R02 - no write at all once locked
// R03 - working copies reload on normal entry, power-on
// R04 - host re-enters normal mode to apply
// R05 - two id words, free data, default zero
// R06 - zero point in 360/4096 degree steps
// R07 - zero point offsets quadrature and commutation angles
// R08 - direction bit selects ccw or cw counting
// R09 - index bit selects pulse or half-turn switch
// R10 - output enable bit drives or floats a/b/z
// R11 - hysteresis code decodes to lsb threshold
// R12 - hysteresis off follows angle directly
// R13 - zero lsb setting masks single-lsb dither
// R14 - resolution codes 0-3 binary ppr
// R15 - resolution codes 4-f decimal ppr
// R16 - lock field 3 open, else locked forever
// R17 - diagnosis disable bits for flux, tracking
// R18 - refused writes change nothing
module cmab_top
  import cmab_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic user_mode_i,
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [11:0] acc_wdata_i,
  input wire logic [11:0] angle_i,
  output logic acc_ack_o,
  output logic acc_refused_o,
  output logic [11:0] acc_rdata_o,
  output logic locked_o,
  output logic quad_a_o,
  output logic quad_b_o,
  output logic quad_z_o,
  output logic quad_oe_o,
  output logic [10:0] quad_ppr_o,
  output logic [11:0] comm_angle_o,
  output logic [6:0] comm_setup_o,
  output logic flux_diag_dis_o,
  output logic track_diag_dis_o
);

  typedef struct packed {
    cmab_bank_t mem;
    cmab_bank_t wk;
    logic boot;
    logic mode;
    logic ack;
    logic refused;
    logic [11:0] rdata;
    logic qa;
    logic qb;
    logic qz;
    logic oe;
    logic [11:0] comm;
  } cmab_state_t;

  // power-on defaults; working copies are loaded from memory by boot
  localparam cmab_bank_t RST_BANK = {`CMAB_RST_CS, `CMAB_RST_DD, `CMAB_RST_LK,
    `CMAB_RST_QS, `CMAB_RST_ZP, `CMAB_RST_ID, `CMAB_RST_ID}; // R05

  localparam cmab_state_t RST_STATE = '{
    mem: RST_BANK,
    wk: RST_BANK,
    boot: 1'b1,
    mode: 1'b0,
    ack: 1'b0,
    refused: 1'b0,
    rdata: 12'h000,
    qa: 1'b0,
    qb: 1'b0,
    qz: 1'b0,
    oe: 1'b0,
    comm: 12'h000
  };

  cmab_state_t q, d;

  logic in_range;
  logic locked;
  logic load;
  logic [2:0] idx;
  logic [11:0] zp;
  logic [11:0] qs;
  logic [11:0] rel;
  logic [11:0] filt;
  logic [2:0] thresh;
  logic [10:0] ppr;
  logic [22:0] prod;
  logic [11:0] abz_ang;
  logic [7:0] idx_full;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  always_comb begin
    in_range = (acc_addr_i >= `CMAB_ADDR_FIRST) && (acc_addr_i <= `CMAB_ADDR_LAST); // R01
    idx_full = acc_addr_i - `CMAB_ADDR_FIRST;
    idx = idx_full[2:0];
    locked = (q.mem[`CMAB_IDX_LK][1:0] != `CMAB_LOCK_OPEN); // R16
    // boot covers power-on; falling user mode is entry to normal
    load = q.boot || (q.mode && !user_mode_i); // R03
  end

  ////////////////////////////////////////////////////////////////////////////
  // setting decode from working copies

  always_comb begin
    zp = q.wk[`CMAB_IDX_ZP]; // R06
    qs = q.wk[`CMAB_IDX_QS];
    // direction flips the sign so cw motion counts up
    rel = qs[`CMAB_BIT_DIR] ? 12'(zp - angle_i) : 12'(angle_i - zp); // R07 R08
    thresh = cmab_hys_thresh(qs[`CMAB_HYS_MSB:`CMAB_HYS_LSB]); // R11
    ppr = cmab_ppr(qs[`CMAB_RES_MSB:`CMAB_RES_LSB]); // R14 R15
    // scaled angle = filt * ppr * 4 / 4096; non power of two loses some linearity
    prod = 23'(filt) * 23'(ppr);
    abz_ang = prod[21:10];
  end

  cmab_hyst u_hyst (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .angle_i(rel),
    .thresh_i(thresh),
    .filt_o(filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.boot = 1'b0;
    d.mode = user_mode_i;
    d.ack = 1'b0;
    d.refused = 1'b0;
    if (load) begin
      d.wk = q.mem; // R03
    end
    if (acc_req_i) begin
      d.ack = 1'b1;
      if (acc_wr_i) begin
        if (user_mode_i && in_range && !locked) begin // R01 R02
          d.mem[idx] = acc_wdata_i; // R16
        end else begin
          // refused write leaves memory and read data alone
          d.refused = 1'b1; // R18
        end
      end else if (user_mode_i && in_range) begin
        d.rdata = q.mem[idx]; // R01
      end else begin
        d.refused = 1'b1;
        d.rdata = 12'h000;
      end
    end
    d.qa = abz_ang[1];
    d.qb = abz_ang[1] ^ abz_ang[0];
    // switch form: high below half turn, low above
    d.qz = qs[`CMAB_BIT_ZMODE] ? (filt < `CMAB_HALF_TURN) : ~|abz_ang; // R09
    d.oe = qs[`CMAB_BIT_QEN]; // R10
    // commutation path sees the offset but not the quadrature hysteresis
    d.comm = rel; // R07
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign acc_ack_o = q.ack;
  assign acc_refused_o = q.refused;
  assign acc_rdata_o = q.rdata;
  assign locked_o = locked;
  assign quad_a_o = q.qa;
  assign quad_b_o = q.qb;
  assign quad_z_o = q.qz;
  assign quad_oe_o = q.oe;
  assign quad_ppr_o = ppr;
  assign comm_angle_o = q.comm;
  assign comm_setup_o = q.wk[`CMAB_IDX_CS][6:0];
  assign flux_diag_dis_o = q.wk[`CMAB_IDX_DD][`CMAB_BIT_FLUX_DIS]; // R17
  assign track_diag_dis_o = q.wk[`CMAB_IDX_DD][`CMAB_BIT_TRACK_DIS]; // R17

  ////////////////////////////////////////////////////////////////////////////
  // checks

  normal_blocked_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i && !user_mode_i |=>
    acc_ack_o && acc_refused_o && ($past(acc_wr_i) || acc_rdata_o == 12'h000))
    else $error("access outside user mode not refused");

  locked_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R02
    acc_req_i && acc_wr_i && locked_o |=> acc_refused_o)
    else $error("write accepted while locked");

  refused_keep_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R18
    acc_req_i && acc_wr_i && (!user_mode_i || locked_o) |=> q.mem == $past(q.mem))
    else $error("refused write changed memory");

  normal_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R03
    q.mode && !user_mode_i |=> q.wk == $past(q.mem))
    else $error("working copy not reloaded");

  lock_sets_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R16
    acc_req_i && acc_wr_i && user_mode_i && !locked_o && acc_addr_i == `CMAB_OFS_LOCK
    && acc_wdata_i[1:0] != 2'h3 |=> locked_o ##1 locked_o)
    else $error("lock write did not lock");

  oe_from_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R10
    q.mode && !user_mode_i && !q.mem[`CMAB_IDX_QS][`CMAB_BIT_QEN] |=> ##1 !quad_oe_o)
    else $error("disabled quadrature still driven");

  ppr_decimal_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R15
    q.wk[`CMAB_IDX_QS][3:0] == 4'hb |-> quad_ppr_o == 11'h168)
    else $error("resolution code b wrong");

  zero_offset_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R07
    !q.wk[`CMAB_IDX_QS][`CMAB_BIT_DIR] && !load |=>
    comm_angle_o == 12'($past(angle_i) - $past(q.wk[`CMAB_IDX_ZP])))
    else $error("zero point not applied");

  dir_reverse_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R08
    q.wk[`CMAB_IDX_QS][`CMAB_BIT_DIR] |=>
    comm_angle_o == 12'($past(q.wk[`CMAB_IDX_ZP]) - $past(angle_i)))
    else $error("reversed direction not applied");

  ack_pulse_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i |=> acc_ack_o)
    else $error("request not acknowledged");

  ack_idle_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    !acc_req_i |=> !acc_ack_o && !acc_refused_o)
    else $error("answer without request");

  range_refused_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i && !in_range |=> acc_refused_o)
    else $error("reserved address not refused");

  user_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i && !acc_wr_i && user_mode_i && in_range |=>
    !acc_refused_o && acc_rdata_o == $past(q.mem[idx]))
    else $error("user mode read wrong");

  user_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i && acc_wr_i && user_mode_i && in_range && !locked_o |=>
    !acc_refused_o && q.mem[$past(idx)] == $past(acc_wdata_i))
    else $error("user mode write lost");

  rdata_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    !acc_req_i |=> $stable(acc_rdata_o))
    else $error("read data changed while idle");

  refused_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R01
    acc_req_i && !acc_wr_i && !in_range |=> acc_rdata_o == 12'h000)
    else $error("reserved read returned data");

  lock_stays_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R16
    locked_o |=> locked_o)
    else $error("lock released");

  lock_open_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R16
    acc_req_i && acc_wr_i && user_mode_i && !locked_o && acc_addr_i == `CMAB_OFS_LOCK
    && acc_wdata_i[1:0] == `CMAB_LOCK_OPEN |=> !locked_o)
    else $error("open lock value locked");

  write_rdata_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R18
    acc_req_i && acc_wr_i |=> $stable(acc_rdata_o))
    else $error("write disturbed read data");

  idle_mem_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R18
    !acc_req_i |=> $stable(q.mem))
    else $error("memory changed without request");

  range_keep_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R18
    acc_req_i && acc_wr_i && !in_range |=> $stable(q.mem))
    else $error("reserved write changed memory");

  user_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R03
    user_mode_i && !q.boot |=> $stable(q.wk))
    else $error("working copy changed in user mode");

  boot_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R03
    q.boot |=> q.wk == $past(q.mem))
    else $error("working copy not loaded at power-on");

  diag_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R17
    load |=>
    flux_diag_dis_o == $past(q.mem[`CMAB_IDX_DD][`CMAB_BIT_FLUX_DIS]) &&
    track_diag_dis_o == $past(q.mem[`CMAB_IDX_DD][`CMAB_BIT_TRACK_DIS]))
    else $error("diagnosis disable not loaded");

  setup_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R03
    load |=> comm_setup_o == $past(q.mem[`CMAB_IDX_CS][6:0]))
    else $error("commutation setup not loaded");

  oe_on_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R10
    load && q.mem[`CMAB_IDX_QS][`CMAB_BIT_QEN] |=> ##1 quad_oe_o)
    else $error("enabled quadrature not driven");

  ppr_default_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R14
    q.wk[`CMAB_IDX_QS][3:0] == 4'h0 |-> quad_ppr_o == 11'h400)
    else $error("resolution code 0 wrong");

  ppr_binary_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R14
    q.wk[`CMAB_IDX_QS][3:0] == 4'h3 |-> quad_ppr_o == 11'h080)
    else $error("resolution code 3 wrong");

  ppr_thousand_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R15
    q.wk[`CMAB_IDX_QS][3:0] == 4'h4 |-> quad_ppr_o == 11'h3e8)
    else $error("resolution code 4 wrong");

  ppr_fifty_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R15
    q.wk[`CMAB_IDX_QS][3:0] == 4'hf |-> quad_ppr_o == 11'h032)
    else $error("resolution code f wrong");

  switch_low_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R09
    qs[`CMAB_BIT_ZMODE] && filt >= `CMAB_HALF_TURN |=> !quad_z_o)
    else $error("switch index high above half turn");

  switch_high_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R09
    qs[`CMAB_BIT_ZMODE] && filt < `CMAB_HALF_TURN |=> quad_z_o)
    else $error("switch index low below half turn");

  index_pulse_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R09
    !qs[`CMAB_BIT_ZMODE] && abz_ang == 12'h000 |=> quad_z_o)
    else $error("index missing at zero");

  hys_off_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R11
    q.wk[`CMAB_IDX_QS][`CMAB_HYS_MSB:`CMAB_HYS_LSB] == 3'h0 |-> thresh == 3'h0)
    else $error("hysteresis off decoded wrong");

  hys_zero_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // R11
    q.wk[`CMAB_IDX_QS][`CMAB_HYS_MSB:`CMAB_HYS_LSB] == 3'h1 |-> thresh == 3'h2)
    else $error("zero lsb hysteresis decoded wrong");

endmodule // cmab_top

// File: test/cmab_host.sv
/*
 host model driving the configuration access port.
 assumes one-cycle request pulses and an answer one cycle later.
*/
`timescale 1ns/10ps

module cmab_host (
  input wire logic core_clk_i,
  input wire logic acc_ack_i,
  input wire logic acc_refused_i,
  input wire logic [11:0] acc_rdata_i,
  output logic acc_req_o,
  output logic acc_wr_o,
  output logic [7:0] acc_addr_o,
  output logic [11:0] acc_wdata_o
);
  initial begin
    acc_req_o = 1'b0;
    acc_wr_o = 1'b0;
    acc_addr_o = 8'h00;
    acc_wdata_o = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // one access; qualifiers flipped on release so stale values never pass
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [11:0] d,
                      output logic [11:0] rd, output logic rf, output logic ak);
    @(posedge core_clk_i);
    #1;
    acc_req_o = 1'b1;
    acc_wr_o = wr;
    acc_addr_o = a;
    acc_wdata_o = d;
    @(posedge core_clk_i);
    #1;
    acc_req_o = 1'b0;
    acc_wr_o = ~wr;
    acc_addr_o = ~a;
    acc_wdata_o = ~d;
    ak = acc_ack_i;
    rf = acc_refused_i;
    rd = acc_rdata_i;
  endtask
endmodule // cmab_host

// File: test/tb_cmab_top.sv
/*
 self-checking bench of the configuration memory block.
 assumes cmab_host as the access port driver.
*/
`timescale 1ns/10ps

module tb_cmab_top;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic user_mode_i = 1'b1;
  logic [11:0] angle_i = 12'h000;
  logic req, wr, ack, refused, locked, qa, qb, qz, oe, flux, track, ak, rf;
  logic [7:0] addr;
  logic [11:0] wdata, rdata, comm_angle, rd;
  logic [10:0] ppr;
  logic [6:0] comm_setup;
  int n_errors = 0;
  int compares = 0;
  logic [11:0] dflt [7] = '{12'h000, 12'h000, 12'h000, 12'h0a0, 12'h003, 12'h000, 12'h052};
  logic [10:0] ptbl [16] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h3e8, 11'h384,
    11'h320, 11'h2bc, 11'h258, 11'h1f4, 11'h190, 11'h168, 11'h12c, 11'h0c8, 11'h064, 11'h032};
  logic [11:0] hcfg [3] = '{12'h080, 12'h090, 12'h180};
  logic [11:0] hang [3][4] = '{'{12'h001, 12'h002, 12'h003, 12'h000},
    '{12'h001, 12'h002, 12'h001, 12'h000}, '{12'h900, 12'h7ff, 12'h801, 12'h000}};
  logic [2:0] hexp [3][4] = '{'{3'h2, 3'h6, 3'h4, 3'h1}, '{3'h1, 3'h6, 3'h6, 3'h1},
    '{3'h0, 3'h5, 3'h2, 3'h1}};

  always #25 core_clk_i = ~core_clk_i;

  cmab_top u_cmab_top (.core_clk_i(core_clk_i), .srst_i(srst_i), .user_mode_i(user_mode_i),
    .acc_req_i(req), .acc_wr_i(wr), .acc_addr_i(addr), .acc_wdata_i(wdata),
    .angle_i(angle_i), .acc_ack_o(ack), .acc_refused_o(refused), .acc_rdata_o(rdata),
    .locked_o(locked), .quad_a_o(qa), .quad_b_o(qb), .quad_z_o(qz), .quad_oe_o(oe),
    .quad_ppr_o(ppr), .comm_angle_o(comm_angle), .comm_setup_o(comm_setup),
    .flux_diag_dis_o(flux), .track_diag_dis_o(track));
  cmab_host u_cmab_host (.core_clk_i(core_clk_i), .acc_ack_i(ack), .acc_refused_i(refused),
    .acc_rdata_i(rdata), .acc_req_o(req), .acc_wr_o(wr), .acc_addr_o(addr),
    .acc_wdata_o(wdata));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [11:0] d);
    u_cmab_host.xfer(w, a, d, rd, rf, ak);
    chk({11'h000, ak}, 12'h001);
  endtask

  // working copies settle one cycle after normal entry, oe and comm outputs two cycles after, a/b/z three cycles after
  task automatic normal();
    @(posedge core_clk_i);
    #1;
    user_mode_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  task automatic print_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk_i);
    #1;
    srst_i = 1'b0;
    for (int i = 0; i < 7; i++) begin
      acc(1'b0, 8'h04 + 8'(i), 12'h000);
      chk(rd, dflt[i]);
    end
    chk({5'h00, comm_setup}, 12'h052);
    acc(1'b0, 8'h03, 12'h000);
    chk({11'h000, rf}, 12'h001);
    chk(rd, 12'h000);
    acc(1'b0, 8'h0b, 12'h000);
    chk({10'h000, rf, |rd}, 12'h002);
    acc(1'b1, 8'h04, 12'ha5c);
    acc(1'b1, 8'h05, 12'h3c3);
    acc(1'b0, 8'h04, 12'h000);
    chk(rd, 12'ha5c);
    acc(1'b0, 8'h05, 12'h000);
    chk(rd, 12'h3c3);
    for (int c = 0; c < 16; c++) begin
      acc(1'b1, 8'h07, {4'h0, 1'(c), 3'h2, 4'(c)});
      chk({1'b0, ppr}, {1'b0, ptbl[(c == 0) ? 0 : c - 1]});
      normal();
      chk({1'b0, ppr}, {1'b0, ptbl[c]});
      chk({11'h000, oe}, 12'(c % 2));
      acc(1'b0, 8'h04, 12'h000);
      chk({11'h000, rf}, 12'h001);
      user_mode_i = 1'b1;
    end
    acc(1'b1, 8'h09, 12'h003);
    acc(1'b1, 8'h0a, 12'h035);
    acc(1'b1, 8'h06, 12'h100);
    acc(1'b1, 8'h07, 12'h0a0);
    angle_i = 12'h180;
    normal();
    chk({10'h000, flux, track}, 12'h003);
    chk(comm_angle, 12'h080);
    chk({5'h00, comm_setup}, 12'h035);
    acc(1'b1, 8'h05, 12'h777);
    chk({11'h000, rf}, 12'h001);
    user_mode_i = 1'b1;
    acc(1'b1, 8'h07, 12'h2a0);
    normal();
    chk(comm_angle, 12'hf80);
    user_mode_i = 1'b1;
    acc(1'b1, 8'h08, 12'h003);
    chk({10'h000, rf, locked}, 12'h000);
    acc(1'b1, 8'h0b, 12'h111);
    chk({11'h000, rf}, 12'h001);
    acc(1'b1, 8'h06, 12'h000);
    for (int h = 0; h < 3; h++) begin
      acc(1'b1, 8'h07, hcfg[h]);
      normal();
      for (int s = 0; s < 4; s++) begin
        angle_i = hang[h][s];
        repeat (2) @(posedge core_clk_i);
        #1;
        chk({9'h000, qa, qb, qz}, {9'h000, hexp[h][s]});
      end
      user_mode_i = 1'b1;
    end
    acc(1'b1, 8'h08, 12'h000);
    chk({10'h000, rf, locked}, 12'h001);
    acc(1'b1, 8'h04, 12'h5a5);
    chk({11'h000, rf}, 12'h001);
    acc(1'b0, 8'h04, 12'h000);
    chk(rd, 12'ha5c);
    acc(1'b0, 8'h05, 12'h000);
    chk(rd, 12'h3c3);
    print_verdict();
  end
endmodule // tb_cmab_top
